// file: bench/hpi_port_assertions.sv
// Concurrent checks on the host port pins.
`timescale 1ns/1ps
module hpi_port_chk #(
    parameter RAM_AWIDTH = 20,
    parameter RAM_BASE   = 0,
    parameter RAM_WORDS  = 20'h4_0000
) (
    input wire                  clk,
    input wire                  rst_n,
    input wire                  host_req,
    input wire [3:0]            host_cmd,
    input wire [19:0]           host_addr,
    input wire [15:0]           host_wdata,
    input wire [15:0]           host_rdata,
    input wire                  host_rvalid,
    input wire                  host_err,
    input wire                  ram_en,
    input wire                  ram_we,
    input wire [RAM_AWIDTH-1:0] ram_addr,
    input wire [15:0]           ram_wdata,
    input wire [15:0]           ram_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_we_with_en: assert property (ram_we |-> ram_en)
        else $error("write without enable");
    chk_en_single: assert property (ram_en |=> !ram_en)
        else $error("enable too long");
    chk_rd_answer: assert property (ram_en && !ram_we |-> ##2 host_rvalid)
        else $error("no answer");
    chk_rd_data: assert property (
        host_rvalid && $past(ram_en, 2) |-> host_rdata == $past(ram_rdata))
        else $error("read data wrong");
    chk_rv_single: assert property (host_rvalid |=> !host_rvalid)
        else $error("valid too long");
    chk_in_window: assert property (ram_en |-> ram_addr - RAM_BASE < RAM_WORDS)
        else $error("outside window");
    chk_wr_data: assert property (ram_we |-> ram_wdata == $past(host_wdata, 3))
        else $error("write data wrong");
    chk_req_synced: assert property (ram_en |-> $past(host_req, 3))
        else $error("early access");
    chk_err_no_access: assert property ($rose(host_err) |-> !ram_en)
        else $error("access despite window error");
    cov_ram_write: cover property (ram_we);
    cov_ram_read: cover property (ram_en && !ram_we);
    cov_window_err: cover property (host_err);
    cov_host_answer: cover property (host_rvalid);
endmodule // hpi_port_chk
bind hpi_port hpi_port_chk #(.RAM_AWIDTH(RAM_AWIDTH), .RAM_BASE(RAM_BASE), .RAM_WORDS(RAM_WORDS))
    i_hpi_port_chk (.*);

// file: bench/hpi_port_test.sv
// Testbench for the host port.
`timescale 1ns/1ps
`include "hpi_defs.vh"
module hpi_port_test;
    reg clk = 0, rst_n = 0, host_req = 0;
    reg [3:0] host_cmd = 4'h0;
    reg [19:0] host_addr = 20'h0_0000;
    reg [15:0] host_wdata = 16'h0000, got = 16'h0000;
    wire [15:0] host_rdata, ram_wdata, ram_rdata;
    wire [19:0] ram_addr;
    wire host_rvalid, host_err, ram_en, ram_we;
    reg [15:0] rv_count = 16'h0000;
    integer fails = 0, check_count = 0;
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        if (host_rvalid === 1'b1)
        begin
            got      <= host_rdata;
            rv_count <= rv_count + 16'h0001;
        end
    end
    hpi_port i_hpi_port (
        .clk         (clk),
        .rst_n       (rst_n),
        .host_req    (host_req),
        .host_cmd    (host_cmd),
        .host_addr   (host_addr),
        .host_wdata  (host_wdata),
        .host_rdata  (host_rdata),
        .host_rvalid (host_rvalid),
        .host_err    (host_err),
        .ram_en      (ram_en),
        .ram_we      (ram_we),
        .ram_addr    (ram_addr),
        .ram_wdata   (ram_wdata),
        .ram_rdata   (ram_rdata)
    );
    hpi_ram_model i_hpi_ram_model (
        .clk       (clk),
        .ram_en    (ram_en),
        .ram_we    (ram_we),
        .ram_addr  (ram_addr),
        .ram_wdata (ram_wdata),
        .ram_rdata (ram_rdata)
    );
    // One request held for six cycles, then a quiet gap of twelve cycles before the check.
    task req(input [3:0] c, input [19:0] a, input [15:0] d);
        reg [15:0] n;
        reg [15:0] want;
    begin
        n = rv_count;
        want = 16'h0000;
        if (c == `HPI_CMD_DIRECT_READ || c == `HPI_CMD_DP_READ || c == `HPI_CMD_DP_READ_INC
            || c == `HPI_CMD_CTRL_READ)
        begin
            want = 16'h0001;
        end
        @(posedge clk);
        #1 host_cmd = c;
        host_addr = a;
        host_wdata = d;
        host_req = 1;
        repeat (6) @(posedge clk);
        #1 host_req = 0;
        repeat (12) @(posedge clk);
        ck(rv_count - n, want);
    end
    endtask
    task ck(input [15:0] g, input [15:0] e);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end
    endtask
    task t_direct;
    begin
        req(`HPI_CMD_DIRECT_WRITE, 20'h1_1400, 16'h1234);
        req(`HPI_CMD_DIRECT_WRITE, 20'h1_1401, 16'h4321);
        req(`HPI_CMD_DIRECT_READ, 20'h1_1400, 16'h0000); ck(got, 16'h1234);
        req(`HPI_CMD_DIRECT_READ, 20'h1_1401, 16'h0000); ck(got, 16'h4321);
        $display("direct test done");
    end
    endtask
    task t_mux;
    begin
        req(`HPI_CMD_ADDR_LOAD, 20'h0_0020, 16'h0000);
        req(`HPI_CMD_DP_WRITE_INC, 20'h0_0000, 16'habcd);
        req(`HPI_CMD_DP_WRITE_INC, 20'h0_0000, 16'h1342);
        req(`HPI_CMD_DP_WRITE, 20'h0_0000, 16'h15b2);
        req(`HPI_CMD_DIRECT_READ, 20'h0_0022, 16'h0000); ck(got, 16'h15b2);
        req(`HPI_CMD_ADDR_LOAD, 20'h0_0020, 16'h0000);
        req(`HPI_CMD_DP_READ_INC, 20'h0_0000, 16'h0000); ck(got, 16'habcd);
        req(`HPI_CMD_DP_READ, 20'h0_0000, 16'h0000); ck(got, 16'h1342);
        req(`HPI_CMD_DP_READ, 20'h0_0000, 16'h0000); ck(got, 16'h1342);
        $display("multiplexed test done");
    end
    endtask
    task t_ctrl_window;
    begin
        req(`HPI_CMD_CTRL_READ, 20'h0_0000, 16'h0000); ck(got, 16'h0000);
        req(`HPI_CMD_CTRL_WRITE, 20'h0_0000, 16'h5a5a);
        req(`HPI_CMD_CTRL_READ, 20'h0_0000, 16'h0000); ck(got, 16'h5a5a);
        req(`HPI_CMD_DIRECT_WRITE, 20'h4_0000, 16'hdead); ck({15'h0000, host_err}, 16'h0001);
        req(`HPI_CMD_DIRECT_READ, 20'h4_0000, 16'h0000); ck(got, 16'h0000);
        req(`HPI_CMD_DIRECT_READ, 20'h1_1400, 16'h0000); ck(got, 16'h1234);
        ck({15'h0000, host_err}, 16'h0000);
        $display("control and window test done");
    end
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        t_direct;
        t_mux;
        t_ctrl_window;
        report_and_stop;
    end
    initial
    begin
        #100000 fails = fails + 1;
        report_and_stop;
    end
endmodule // hpi_port_test

// file: bench/hpi_ram_model.sv
// Synchronous single access RAM behind the host port.
`timescale 1ns/1ps
module hpi_ram_model (input clk, input ram_en, input ram_we, input [19:0] ram_addr,
    input [15:0] ram_wdata, output reg [15:0] ram_rdata);
    reg [15:0] mem [0:4095];
    initial ram_rdata = 16'h0000;
    always @(posedge clk)
    begin
        if (ram_en && ram_we) mem[ram_addr[11:0]] <= ram_wdata;
        ram_rdata <= (ram_en && !ram_we) ? mem[ram_addr[11:0]] : ~ram_rdata;
    end
endmodule // hpi_ram_model

// file: src/hpi_defs.vh
// Constants for the host port block.
`ifndef HPI_DEFS_VH
`define HPI_DEFS_VH
`define HPI_CMD_DIRECT_WRITE   4'h1
`define HPI_CMD_DIRECT_READ    4'h2
`define HPI_CMD_ADDR_LOAD      4'h3
`define HPI_CMD_DP_WRITE       4'h4
`define HPI_CMD_DP_WRITE_INC   4'h5
`define HPI_CMD_DP_READ        4'h6
`define HPI_CMD_DP_READ_INC    4'h7
`define HPI_CMD_CTRL_READ      4'h8
`define HPI_CMD_CTRL_WRITE     4'h9
`define HPI_ADDR_RST           16'h0000
`define HPI_CTRL_RST           16'h0000
`define HPI_DATA_RST           16'h0000
`define HPI_GAP_CYCLES         15
`endif

// file: src/hpi_port.v
// Host port giving an external host access to the internal single access RAM.
//
// Overview of operation
// - Address is 16 bits when multiplexed, 20 bits when direct.
// - Every data word exchanged with the host is 16 bits wide.
// - Direct write stores data at the address given with the request.
// - Direct read returns the word at the address given with the request.
// - Address load sets the host address register for later data port accesses.
// - Data port write with increment stores at the address, then increments it.
// - Data port read returns the addressed word, address left unchanged.
// - Data port read with increment returns the word, then advances address.
// - Host can write the control register and read it back.
// - Host accesses reach only the internal single access RAM.
// - Each request is taken in one cycle; read data returns to the host.
`timescale 1ns/1ps
`include "hpi_defs.vh"
module hpi_port #(
    parameter RAM_AWIDTH = 20,
    parameter RAM_BASE   = 20'h0_0000,
    parameter RAM_WORDS  = 20'h4_0000
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        host_req,
    input  wire [3:0]  host_cmd,
    input  wire [19:0] host_addr,
    input  wire [15:0] host_wdata,
    output wire [15:0] host_rdata,
    output wire        host_rvalid,
    output wire        host_err,
    output wire        ram_en,
    output wire        ram_we,
    output wire [RAM_AWIDTH-1:0] ram_addr,
    output wire [15:0] ram_wdata,
    input  wire [15:0] ram_rdata
);
    reg  [2:0]  req_sync_reg;
    reg  [3:0]  cmd_sync1_reg;
    reg  [3:0]  cmd_reg;
    reg  [19:0] addr_sync1_reg;
    reg  [19:0] addr_s_reg;
    reg  [15:0] wdata_sync1_reg;
    reg  [15:0] wdata_s_reg;
    reg  [15:0] host_addr_reg;
    reg  [15:0] host_ctrl_reg;
    reg         rd_pend_reg;
    reg         rd_wait_reg;
    reg  [15:0] host_rdata_reg;
    reg         host_rvalid_reg;
    reg         host_err_reg;
    reg         ram_en_reg;
    reg         ram_we_reg;
    reg  [RAM_AWIDTH-1:0] ram_addr_reg;
    reg  [15:0] ram_wdata_reg;
    wire        req_pulse;
    reg  [19:0] acc_addr;
    reg         in_ram;
    reg         mem_cmd;
    reg         mem_wr;
    reg         mem_rd;
    reg         inc;

    assign req_pulse = req_sync_reg[1] & ~req_sync_reg[2];

    assign host_rdata  = host_rdata_reg;
    assign host_rvalid = host_rvalid_reg;
    assign host_err    = host_err_reg;
    assign ram_en      = ram_en_reg;
    assign ram_we      = ram_we_reg;
    assign ram_addr    = ram_addr_reg;
    assign ram_wdata   = ram_wdata_reg;

    always @*
    begin
        mem_cmd = 1'b0;
        mem_wr  = 1'b0;
        mem_rd  = 1'b0;
        inc     = 1'b0;
        acc_addr = {4'h0, host_addr_reg};
        case (cmd_reg)
            `HPI_CMD_DIRECT_WRITE:
            begin
                mem_wr = 1'b1;
                acc_addr = addr_s_reg;
            end
            `HPI_CMD_DIRECT_READ:
            begin
                mem_rd = 1'b1;
                acc_addr = addr_s_reg;
            end
            `HPI_CMD_DP_WRITE:      mem_wr = 1'b1;
            `HPI_CMD_DP_WRITE_INC:
            begin
                mem_wr = 1'b1;
                inc = 1'b1;
            end
            `HPI_CMD_DP_READ:       mem_rd = 1'b1;
            `HPI_CMD_DP_READ_INC:
            begin
                mem_rd = 1'b1;
                inc = 1'b1;
            end
            default:                mem_cmd = 1'b0;
        endcase
        mem_cmd = mem_wr | mem_rd;
        in_ram = (acc_addr >= RAM_BASE) && (acc_addr - RAM_BASE < RAM_WORDS);
    end

    // Strobe synchroniser and first stage of the request fields.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_sync_reg    <= 3'b000;
            cmd_sync1_reg   <= 4'h0;
            addr_sync1_reg  <= 20'h0_0000;
            wdata_sync1_reg <= `HPI_DATA_RST;
        end
        else
        begin
            req_sync_reg    <= {req_sync_reg[1:0], host_req};
            cmd_sync1_reg   <= host_cmd;
            addr_sync1_reg  <= host_addr;
            wdata_sync1_reg <= host_wdata;
        end
    end

    // Request capture; the command lives for one cycle only.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_reg     <= 4'h0;
            addr_s_reg  <= 20'h0_0000;
            wdata_s_reg <= `HPI_DATA_RST;
        end
        else
        begin
            if (req_pulse)
            begin
                cmd_reg     <= cmd_sync1_reg;
                addr_s_reg  <= addr_sync1_reg;
                wdata_s_reg <= wdata_sync1_reg;
            end
            else
            begin
                cmd_reg <= 4'h0;
            end
        end
    end

    // Host address and control registers.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_addr_reg <= `HPI_ADDR_RST;
            host_ctrl_reg <= `HPI_CTRL_RST;
        end
        else
        begin
            if (mem_cmd && inc)
            begin
                host_addr_reg <= host_addr_reg + 16'h0001;
            end
            if (cmd_reg == `HPI_CMD_ADDR_LOAD)
            begin
                host_addr_reg <= addr_s_reg[15:0];
            end
            if (cmd_reg == `HPI_CMD_CTRL_WRITE)
            begin
                host_ctrl_reg <= wdata_s_reg;
            end
        end
    end

    // Memory access; read data is taken two cycles after the enable.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ram_en_reg    <= 1'b0;
            ram_we_reg    <= 1'b0;
            ram_addr_reg  <= {RAM_AWIDTH{1'b0}};
            ram_wdata_reg <= `HPI_DATA_RST;
            rd_pend_reg   <= 1'b0;
            rd_wait_reg   <= 1'b0;
        end
        else
        begin
            ram_en_reg  <= mem_cmd & in_ram;
            ram_we_reg  <= mem_wr & in_ram;
            rd_pend_reg <= mem_rd & in_ram;
            rd_wait_reg <= rd_pend_reg;
            if (mem_cmd & in_ram)
            begin
                ram_addr_reg  <= acc_addr[RAM_AWIDTH-1:0];
                ram_wdata_reg <= wdata_s_reg;
            end
        end
    end

    // Answers to the host and the window error flag.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_rdata_reg  <= `HPI_DATA_RST;
            host_rvalid_reg <= 1'b0;
            host_err_reg    <= 1'b0;
        end
        else
        begin
            host_rvalid_reg <= 1'b0;
            if (mem_cmd)
            begin
                host_err_reg <= ~in_ram;
            end
            if (mem_rd & ~in_ram)
            begin
                host_rdata_reg  <= `HPI_DATA_RST;
                host_rvalid_reg <= 1'b1;
            end
            if (cmd_reg == `HPI_CMD_CTRL_READ)
            begin
                host_rdata_reg  <= host_ctrl_reg;
                host_rvalid_reg <= 1'b1;
            end
            if (rd_wait_reg)
            begin
                host_rdata_reg  <= ram_rdata;
                host_rvalid_reg <= 1'b1;
            end
        end
    end
endmodule // hpi_port
